// ### test/cdc_far_model.sv
`timescale 1ns/1ps
// far side: comparator bank plus adc and interrupt controller pulse counters
module cdc_far_model #(
    parameter int N = 4
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [N-1:0] enable_in, // comparator power from the block
    input wire logic [N-1:0] above_in, // analog input above the dac threshold
    input wire logic adc_trigger_in, // channel 0 trigger towards the adc
    input wire logic irq_pulse_in, // channel 0 request towards the interrupt controller
    output logic [N-1:0] raw_out, // comparator outputs
    output int trig_cycles_out, // clocks seen with the trigger high
    output int irq_cycles_out // clocks seen with the request high
);
    // an unpowered comparator cannot report a crossing, so it reads low
    assign raw_out = enable_in & above_in;
    // counting high clocks rather than edges also exposes a stretched pulse
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            trig_cycles_out <= 0;
            irq_cycles_out <= 0;
        end else begin
            trig_cycles_out <= trig_cycles_out + int'(adc_trigger_in);
            irq_cycles_out <= irq_cycles_out + int'(irq_pulse_in);
        end
    end
endmodule // cdc_far_model

// ### test/tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
// register-level bench for the comparator control block
module tb;
    import cdc_pkg::*;
    localparam int N = 4;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic sleep_in = 1'b0;
    logic idle_in = 1'b0;
    logic [N-1:0] above = '0; // analog stimulus handed to the far side model
    logic [N-1:0] cmp_raw;
    logic [15:0] rdata_out;
    logic [N-1:0] cmp_enable_out, adc_trigger_out, irq_pulse_out, wake_out;
    logic [N*2-1:0] input_select_out, ref_select_out;
    logic [N*4-1:0] pad_buffer_disable_out;
    logic [N*10-1:0] dac_code_out;
    logic irq_out;
    int trig_cycles, irq_cycles, failures = 0, n_tests = 0, t0;
    logic [15:0] rd_val; // data captured by the read task
    logic [15:0] ref_ctl [4] = '{16'h8000, 16'h8001, 16'h8021, 16'h0001};
    cdc_ref_t ref_exp [4] = '{CDC_REF_INTERNAL, CDC_REF_HALF_SUPPLY, CDC_REF_EXTERNAL, CDC_REF_OFF};

    cdc_comparator_ctrl #(.N(N), .DAC_W(10)) i_cdc_comparator_ctrl (.clk_in(clk_in), .resetn_in(resetn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .sleep_in(sleep_in), .idle_in(idle_in), .cmp_raw_in(cmp_raw), .cmp_enable_out(cmp_enable_out),
        .input_select_out(input_select_out), .pad_buffer_disable_out(pad_buffer_disable_out),
        .dac_code_out(dac_code_out), .ref_select_out(ref_select_out), .adc_trigger_out(adc_trigger_out),
        .irq_pulse_out(irq_pulse_out), .wake_out(wake_out), .irq_out(irq_out));
    cdc_far_model #(.N(N)) i_cdc_far_model (.clk_in(clk_in), .resetn_in(resetn_in), .enable_in(cmp_enable_out),
        .above_in(above), .adc_trigger_in(adc_trigger_out[0]), .irq_pulse_in(irq_pulse_out[0]),
        .raw_out(cmp_raw), .trig_cycles_out(trig_cycles), .irq_cycles_out(irq_cycles));

    // 40 mhz instruction clock
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    // one-cycle write strobe; registered outputs follow one edge after the taking edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
        #1;
    endtask
    // read data stand only in the cycle after the strobe, so grab them there
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        rd_val = rdata_out;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic results;
        if (failures == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // hang guard: a stuck run counts as a mismatch
    initial begin
        #200000;
        failures++;
        results();
    end
    initial begin
        cyc(5);
        resetn_in <= 1'b1;
        #1;
        `CHK("ref_rst", {N{2'b11}}, ref_select_out)
        rd(8'h00); `CHK("ctrl_rst", 16'h0000, rd_val)
        wr(8'h00, 16'hFFFC); rd(8'h00); `CHK("ctrl_bits", 16'hA0E0, rd_val)
        wr(8'h01, 16'hFFFF); rd(8'h01); `CHK("dac_bits", 16'h03FF, rd_val)
        `CHK("dac_out", 10'h3FF, dac_code_out[9:0])
        wr(8'h00, 16'h0000); `CHK("dac_off", 10'h000, dac_code_out[9:0])
        `CHK("en_off", 1'b0, cmp_enable_out[0])
        `CHK("pad_off", 4'h0, pad_buffer_disable_out[3:0])
        for (int s = 0; s < 4; s++) begin
            wr(8'h00, 16'h8000 | (16'(s) << 6));
            `CHK("input_source_select", 2'(s), input_select_out[1:0])
            `CHK("pad", 4'(1 << s), pad_buffer_disable_out[3:0])
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, ref_ctl[i]); `CHK("ref", ref_exp[i], ref_select_out[1:0])
        end
        // a two-clock glitch must vanish, a held level must give one pulse
        wr(8'h21, 16'h0001);
        wr(8'h00, 16'h8000);
        t0 = trig_cycles;
        @(posedge clk_in);
        above[0] <= 1'b1;
        repeat (2) @(posedge clk_in);
        above[0] <= 1'b0;
        cyc(10); `CHK("glitch", t0, trig_cycles)
        @(posedge clk_in);
        above[0] <= 1'b1;
        for (int k = 0; k < 20 && trig_cycles == t0; k++) @(posedge clk_in);
        if (trig_cycles == t0) begin
            failures++;
            results();
        end
        cyc(4); `CHK("trig_w", t0 + 1, trig_cycles)
        `CHK("irq_w", t0 + 1, irq_cycles)
        `CHK("irq_lvl", 1'b1, irq_out)
        rd(8'h20); `CHK("status", 16'h0001, rd_val)
        rd(8'h00); `CHK("stat_bit", 16'h8008, rd_val)
        wr(8'h20, 16'h0001); cyc(2); `CHK("irq_clr", 1'b0, irq_out)
        // inverted polarity: falling input becomes a rising event, masked here
        wr(8'h21, 16'h0000);
        wr(8'h00, 16'h8002); cyc(6); rd(8'h00); `CHK("pol_stat", 16'h8002, rd_val)
        @(posedge clk_in);
        above[0] <= 1'b0;
        cyc(8); `CHK("pol_trig", t0 + 2, trig_cycles)
        `CHK("irq_mask", 1'b0, irq_out)
        rd(8'h20); `CHK("status2", 16'h0001, rd_val)
        wr(8'h20, 16'h0001);
        // sleep: unfiltered path follows the comparator
        wr(8'h00, 16'h8000);
        sleep_in <= 1'b1;
        above[0] <= 1'b1;
        cyc(2); `CHK("wake_hi", 1'b1, wake_out[0])
        above[0] <= 1'b0;
        cyc(2); `CHK("wake_lo", 1'b0, wake_out[0])
        sleep_in <= 1'b0;
        // idle: one idle-stop bit stops the whole group
        wr(8'h02, 16'hA000);
        idle_in <= 1'b1;
        above[0] <= 1'b1;
        cyc(2); `CHK("idle_grp", 2'b00, cmp_enable_out[1:0])
        `CHK("idle_wake", 1'b0, wake_out[0])
        idle_in <= 1'b0;
        wr(8'h02, 16'h8000);
        idle_in <= 1'b1;
        cyc(2); `CHK("idle_run", 2'b11, cmp_enable_out[1:0])
        `CHK("idle_wk", 1'b1, wake_out[0])
        idle_in <= 1'b0;
        wr(8'h30, 16'hFFFF); rd(8'h30); `CHK("unmapped", 16'h0000, rd_val)
        results();
    end
endmodule // tb

// ### verilog/cdc_comparator_ctrl.sv
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "cdc_defs.svh"
// digital control around N comparators with reference dacs
module cdc_comparator_ctrl
    import cdc_pkg::*;
#(
    parameter int N = 4,
    parameter int DAC_W = 10
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic sleep_in,
    input wire logic idle_in,
    input wire logic [N-1:0] cmp_raw_in,
    output logic [N-1:0] cmp_enable_out,
    output logic [N*2-1:0] input_select_out,
    output logic [N*4-1:0] pad_buffer_disable_out,
    output logic [N*DAC_W-1:0] dac_code_out,
    output logic [N*2-1:0] ref_select_out,
    output logic [N-1:0] adc_trigger_out,
    output logic [N-1:0] irq_pulse_out,
    output logic [N-1:0] wake_out,
    output logic irq_out
);
    logic [15:0] ctrl [N];           // comparator_control per channel
    logic [DAC_W-1:0] dac_value [N]; // dac_value_register per channel
    logic [N-1:0] int_status;        // sticky event bits
    logic [N-1:0] int_mask;          // one enables the event onto irq_out
    logic [N-1:0] sidl_bits;         // idle_stop_select of every channel
    logic [N-1:0] active;            // channel comparator running
    logic [N-1:0] pol_state;         // raw output after polarity
    logic [N-1:0] filt;              // filtered state
    logic [N-1:0] filt_d;            // previous filtered state for edges
    logic [N-1:0] event_pulse;       // one-cycle event
    logic low_power;                 // sleep or idle: filter bypassed

    assign low_power = sleep_in | idle_in;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_ch
            assign sidl_bits[g] = ctrl[g][`CDC_BIT_SIDL];
            // group shuts down in idle if any idle-stop bit is set
            // also off whenever comparator_on is clear
            assign active[g] = ctrl[g][`CDC_BIT_ON] & ~(idle_in & (|sidl_bits)) & ~sleep_in;
            // polarity inverts before the filter and status
            assign pol_state[g] = cmp_raw_in[g] ^ ctrl[g][`CDC_BIT_POL];

            cdc_glitch_filter #(.CYCLES(`CDC_FILTER_CYCLES)) u_filt (
                .clk_in(clk_in),
                .resetn_in(resetn_in),
                .raw_in(pol_state[g]),
                .clear_in(~active[g]),
                .filt_out(filt[g])
            );

            // dac, source select and pad buffers follow the registers
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    cmp_enable_out[g] <= 1'b0;
                    dac_code_out[g*DAC_W +: DAC_W] <= '0;
                    input_select_out[g*2 +: 2] <= 2'h0;
                    pad_buffer_disable_out[g*4 +: 4] <= 4'h0;
                    ref_select_out[g*2 +: 2] <= CDC_REF_OFF;
                end else begin
                    // powered while on, except in idle with any idle-stop bit set
                    // sleep leaves it powered so the wake path can still see a crossing
                    cmp_enable_out[g] <= ctrl[g][`CDC_BIT_ON] & ~(idle_in & (|sidl_bits));
                    // held at zero when off so the dac draws nothing
                    dac_code_out[g*DAC_W +: DAC_W] <= ctrl[g][`CDC_BIT_ON] ? dac_value[g] : '0;
                    input_select_out[g*2 +: 2] <= ctrl[g][`CDC_BIT_INPUT_SOURCE_SELECT_HI:`CDC_BIT_INPUT_SOURCE_SELECT_LO];
                    // one-hot pad a..d, only while enabled
                    pad_buffer_disable_out[g*4 +: 4] <= ctrl[g][`CDC_BIT_ON]
                        ? 4'(4'h1 << ctrl[g][`CDC_BIT_INPUT_SOURCE_SELECT_HI:`CDC_BIT_INPUT_SOURCE_SELECT_LO]) : 4'h0;
                    if (!ctrl[g][`CDC_BIT_ON])
                        ref_select_out[g*2 +: 2] <= CDC_REF_OFF;
                    else if (ctrl[g][`CDC_BIT_EXTERNAL_REFERENCE_ENABLE])
                        ref_select_out[g*2 +: 2] <= CDC_REF_EXTERNAL;
                    else if (ctrl[g][`CDC_BIT_RANGE])
                        ref_select_out[g*2 +: 2] <= CDC_REF_HALF_SUPPLY;
                    else
                        ref_select_out[g*2 +: 2] <= CDC_REF_INTERNAL;
                end
            end
        end
    endgenerate

    // rising edge of the filtered state is the comparator event
    assign event_pulse = filt & ~filt_d;

    // edge detect and one-cycle pulse outputs
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            filt_d <= '0;
            adc_trigger_out <= '0;
            irq_pulse_out <= '0;
        end else begin
            filt_d <= filt;
            adc_trigger_out <= event_pulse;
            irq_pulse_out <= event_pulse;
        end
    end

    // asynchronous unfiltered path in sleep/idle; registered only for the
    // outputs-from-flops style, the analog wake path itself stays combinational
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
            wake_out <= '0;
        else
            wake_out <= low_power ? (pol_state & {N{1'b1}} & active_or_sleep()) : '0;
    end

    // in sleep the active flag drops, but the wake path must still see enabled channels
    function automatic logic [N-1:0] active_or_sleep();
        logic [N-1:0] r;
        r = '0;
        for (int i = 0; i < N; i++)
            r[i] = ctrl[i][`CDC_BIT_ON] & ~(idle_in & (|sidl_bits));
        return r;
    endfunction

    // register writes; channel index in bits 7:1, register in bit 0
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < N; i++) begin
                ctrl[i] <= `CDC_CTRL_RESET;
                dac_value[i] <= DAC_W'(`CDC_DAC_RESET);
            end
            int_mask <= '0;
        end else if (wr_in) begin
            for (int i = 0; i < N; i++) begin
                if (addr_in == 8'(2 * i) + 8'(`CDC_CTRL_IDX))
                    ctrl[i] <= wdata_in & `CDC_CTRL_WMASK;
                if (addr_in == 8'(2 * i) + 8'(`CDC_DAC_IDX))
                    dac_value[i] <= DAC_W'(wdata_in & `CDC_DAC_WMASK);
            end
            if (addr_in == `CDC_INT_MASK)
                int_mask <= wdata_in[N-1:0];
        end
    end

    // sticky status: a new event wins over a write-one clear
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
            int_status <= '0;
        else if (wr_in && addr_in == `CDC_INT_STATUS)
            int_status <= (int_status & ~wdata_in[N-1:0]) | event_pulse;
        else
            int_status <= int_status | event_pulse;
    end

    // level interrupt from registered status and mask
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
            irq_out <= 1'b0;
        else
            irq_out <= |(int_status & int_mask);
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= 16'h0000;
        end else begin
            rdata_out <= 16'h0000;
            if (rd_in) begin
                for (int i = 0; i < N; i++) begin
                    if (addr_in == 8'(2 * i) + 8'(`CDC_CTRL_IDX)) begin
                        rdata_out <= ctrl[i];
                        rdata_out[`CDC_BIT_STAT] <= filt[i];
                    end
                    if (addr_in == 8'(2 * i) + 8'(`CDC_DAC_IDX))
                        rdata_out <= 16'(dac_value[i]);
                end
                if (addr_in == `CDC_INT_STATUS)
                    rdata_out <= 16'(int_status);
                if (addr_in == `CDC_INT_MASK)
                    rdata_out <= 16'(int_mask);
            end
        end
    end

    // helper: cycles since the unfiltered level pol_state[0] last changed
    logic [3:0] stable_cnt;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
            stable_cnt <= 4'h0;
        else if (pol_state[0] != $past(pol_state[0]))
            stable_cnt <= 4'h0;
        else if (stable_cnt != 4'hF)
            stable_cnt <= stable_cnt + 4'h1;
    end

    sequence s_event0;
        !filt_d[0] ##0 filt[0];
    endsequence

    property p_filter;
        @(posedge clk_in) disable iff (!resetn_in)
        $rose(filt[0]) |-> $past(stable_cnt) >= 4'h1;
    endproperty
    a_filter: assert property (p_filter) else $error("filter passed a short pulse");

    property p_pulse;
        @(posedge clk_in) disable iff (!resetn_in)
        s_event0 |=> adc_trigger_out[0] ##1 !adc_trigger_out[0];
    endproperty
    a_pulse: assert property (p_pulse) else $error("trigger not one cycle");

    property p_irqpulse;
        @(posedge clk_in) disable iff (!resetn_in)
        irq_pulse_out[0] == adc_trigger_out[0];
    endproperty
    a_irqpulse: assert property (p_irqpulse) else $error("irq pulse differs from trigger");

    property p_wake;
        @(posedge clk_in) disable iff (!resetn_in)
        wake_out[0] |-> $past(low_power);
    endproperty
    a_wake: assert property (p_wake) else $error("wake outside low power");

    property p_group_idle;
        @(posedge clk_in) disable iff (!resetn_in)
        (idle_in && (|sidl_bits)) |=> cmp_enable_out == '0;
    endproperty
    a_group_idle: assert property (p_group_idle) else $error("comparator alive in idle");

    property p_off;
        @(posedge clk_in) disable iff (!resetn_in)
        !ctrl[0][`CDC_BIT_ON] |=> !cmp_enable_out[0] && dac_code_out[DAC_W-1:0] == '0;
    endproperty
    a_off: assert property (p_off) else $error("dac or comparator on while off");

    property p_pad;
        @(posedge clk_in) disable iff (!resetn_in)
        ctrl[0][`CDC_BIT_ON] |=> $onehot(pad_buffer_disable_out[3:0]);
    endproperty
    a_pad: assert property (p_pad) else $error("pad buffer not disabled");

    property p_irq;
        @(posedge clk_in) disable iff (!resetn_in)
        (int_status[0] && int_mask[0]) |=> irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule // cdc_comparator_ctrl

// ### verilog/cdc_defs.svh
// Overview of operation
// - filter masks comparator pulses under three cycles
// - sleep or idle bypasses filter, async path
// - async path wakes processor from sleep/idle
// - idle-stop bit disables comparator during idle
// - any idle-stop bit disables whole group idle
// - one-cycle pulse triggers adc and interrupt
// - dac input driven from dac value register
// - comparator_on clear disables dac and comparator
// - reference: half supply, internal, or external
// - enabled comparator disables chosen pad buffer
// - dac level is code times full scale /1024
`ifndef CDC_DEFS_SVH
`define CDC_DEFS_SVH
`define CDC_CTRL_IDX 4'h0
`define CDC_DAC_IDX 4'h1
`define CDC_INT_STATUS 8'h20
`define CDC_INT_MASK 8'h21
`define CDC_BIT_ON 15
`define CDC_BIT_SIDL 13
`define CDC_BIT_INPUT_SOURCE_SELECT_HI 7
`define CDC_BIT_INPUT_SOURCE_SELECT_LO 6
`define CDC_BIT_EXTERNAL_REFERENCE_ENABLE 5
`define CDC_BIT_STAT 3
`define CDC_BIT_POL 1
`define CDC_BIT_RANGE 0
`define CDC_CTRL_WMASK 16'hA0E3
`define CDC_DAC_WMASK 16'h03FF
`define CDC_CTRL_RESET 16'h0000
`define CDC_DAC_RESET 16'h0000
`define CDC_FILTER_NS 66
`define CDC_CLK_PERIOD_NS 25
// least time rounds up: 66 ns at 25 ns gives 3 cycles
`define CDC_FILTER_CYCLES ((`CDC_FILTER_NS + `CDC_CLK_PERIOD_NS - 1) / `CDC_CLK_PERIOD_NS)
`endif

// ### verilog/cdc_glitch_filter.sv
`timescale 1ns/1ps
`include "cdc_defs.svh"
// one channel: accept a new level only after it has held for CYCLES clocks
module cdc_glitch_filter #(
    parameter int CYCLES = `CDC_FILTER_CYCLES
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic raw_in,
    input wire logic clear_in,
    output logic filt_out
);
    localparam int CW = $clog2(CYCLES + 1) > 0 ? $clog2(CYCLES + 1) : 1;
    logic [CW-1:0] hold_count; // cycles the raw level has differed

    // count while the raw level disagrees; restart on any bounce
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hold_count <= '0;
            filt_out <= 1'b0;
        end else if (clear_in) begin
            hold_count <= '0;
            filt_out <= 1'b0;
        end else if (raw_in == filt_out) begin
            hold_count <= '0;
        end else if (hold_count == CW'(CYCLES - 1)) begin
            // short pulses never get here, so they are masked
            hold_count <= '0;
            filt_out <= raw_in;
        end else begin
            hold_count <= hold_count + CW'(1);
        end
    end
endmodule // cdc_glitch_filter

// ### verilog/cdc_pkg.sv
package cdc_pkg;
    // reference source seen by the dac multiplexer
    typedef enum logic [1:0] {
        CDC_REF_INTERNAL,
        CDC_REF_HALF_SUPPLY,
        CDC_REF_EXTERNAL,
        CDC_REF_OFF
    } cdc_ref_t;
endpackage
